// file: src/suvmc_defs.svh
// Constants of the supply undervoltage and mode control block
//
// Notes on behaviour
// - Battery dip counts only beyond blanking time
// - Battery event sets battery bit and error
// - Battery timer expiry sets flag, forces sleep
// - Battery flag blocks host and controller ports
// - Core dip counts only beyond blanking time
// - Core event sets core bit and error
// - Core timer expiry blocks host, forces standby
// - Host stays usable while core timer runs
// - Core undervoltage disables transmitter, sets bus-error
// - I/O undervoltage handled like battery undervoltage
// - After reaction time block ports, outputs low
// - I/O dip counts only beyond blanking time
// - I/O event sets bits; expiry sets flag, sleep
// - I/O undervoltage holds receive data, activity and error outputs low
// - Both battery and core down means powered off
// - Powered off: outputs low, functions inoperative; host, controller and guard blocked outputs are held high
// - Either battery or core supply powers up
// - Both supplies good: standby within settle time
// - Incomplete power-up: interim standby, host refused
// - Interim starts detect timers; completion gives standby
// - Expiry in interim sets missing supply flag
// - Recovery during detect timer sets no flag
// - Recovery timer clears flag; relapse keeps it
// - Status bits cleared by power-down or clear
`ifndef SUVMC_DEFS_SVH
`define SUVMC_DEFS_SVH

`define SUVMC_CNT_W 16
`define SUVMC_CLK_NS 50

// Least times, rounded up to whole cycles
`define SUVMC_CYC(ns) (((ns) + `SUVMC_CLK_NS - 1) / `SUVMC_CLK_NS)
`define SUVMC_BAT_BLK_NS 10000
`define SUVMC_BAT_DET_NS 100000
`define SUVMC_BAT_REC_NS 100000
`define SUVMC_CORE_BLK_NS 10000
`define SUVMC_CORE_DET_NS 100000
`define SUVMC_CORE_REC_NS 100000
`define SUVMC_IO_BLK_NS 10000
`define SUVMC_IO_DET_NS 100000
`define SUVMC_IO_REC_NS 100000
`define SUVMC_IO_REACT_NS 1000
`define SUVMC_PWRUP_NS 200000

// Register byte offsets
`define SUVMC_OFS_STATUS 8'h00
`define SUVMC_OFS_CTRL 8'h04
`define SUVMC_OFS_MODE 8'h08
`define SUVMC_OFS_CLEAR 8'h0c

// Status bit positions
`define SUVMC_BIT_BUSERR 4
`define SUVMC_BIT_BATUV 8
`define SUVMC_BIT_COREUV 9
`define SUVMC_BIT_IOUV 10
`define SUVMC_BIT_ERR 11

// Host-selected modes
`define SUVMC_HOST_STANDBY 2'h0
`define SUVMC_HOST_NORMAL 2'h1
`define SUVMC_HOST_RXONLY 2'h2
`define SUVMC_HOST_SLEEP 2'h3

// Effective mode codes
`define SUVMC_MODE_OFF 3'h0
`define SUVMC_MODE_STANDBY 3'h1
`define SUVMC_MODE_NORMAL 3'h2
`define SUVMC_MODE_RXONLY 3'h3
`define SUVMC_MODE_SLEEP 3'h4
`define SUVMC_MODE_INTERIM 3'h5

`define SUVMC_SIR_RST 12'h000

`endif

// file: src/suvmc_pkg.sv
// Types of the supply undervoltage and mode control block
`include "suvmc_defs.svh"
`default_nettype none
package suvmc_pkg;

    typedef enum logic [1:0] {ST_OFF, ST_POWERUP, ST_INTERIM, ST_RUN} suvmc_state_type;

    typedef struct packed {
        logic bat_uv;
        logic core_uv;
        logic io_uv;
        logic bat_pd;
        logic core_pd;
    } suvmc_supply_type;

    typedef struct packed {
        logic [`SUVMC_CNT_W-1:0] blk;
        logic [`SUVMC_CNT_W-1:0] det;
        logic [`SUVMC_CNT_W-1:0] rec;
        logic det_run;
        logic flag;
        logic evt;
    } suvmc_chan_type;

endpackage : suvmc_pkg
`default_nettype wire

// file: src/suvmc_top.sv
// Supply undervoltage supervision, power-up sequencing and APB status registers
`include "suvmc_defs.svh"
`default_nettype none
module suvmc_top
    import suvmc_pkg::*;
#(
    parameter logic [15:0] P_BAT_BLK = 16'(`SUVMC_CYC(`SUVMC_BAT_BLK_NS)),
    parameter logic [15:0] P_BAT_DET = 16'(`SUVMC_CYC(`SUVMC_BAT_DET_NS)),
    parameter logic [15:0] P_BAT_REC = 16'(`SUVMC_CYC(`SUVMC_BAT_REC_NS)),
    parameter logic [15:0] P_CORE_BLK = 16'(`SUVMC_CYC(`SUVMC_CORE_BLK_NS)),
    parameter logic [15:0] P_CORE_DET = 16'(`SUVMC_CYC(`SUVMC_CORE_DET_NS)),
    parameter logic [15:0] P_CORE_REC = 16'(`SUVMC_CYC(`SUVMC_CORE_REC_NS)),
    parameter logic [15:0] P_IO_BLK = 16'(`SUVMC_CYC(`SUVMC_IO_BLK_NS)),
    parameter logic [15:0] P_IO_DET = 16'(`SUVMC_CYC(`SUVMC_IO_DET_NS)),
    parameter logic [15:0] P_IO_REC = 16'(`SUVMC_CYC(`SUVMC_IO_REC_NS)),
    parameter logic [15:0] P_IO_REACT = 16'(`SUVMC_CYC(`SUVMC_IO_REACT_NS)),
    parameter logic [15:0] P_PWRUP = 16'(`SUVMC_CYC(`SUVMC_PWRUP_NS))
)
(
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire suvmc_supply_type i_sup,
    input wire logic i_bus_rx_data,
    input wire logic i_bus_rx_act,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic [2:0] o_mode,
    output logic o_tx_en,
    output logic o_rx_en,
    output logic o_rx_data,
    output logic o_receive_activity_output,
    output logic o_error_indication_output_n,
    output logic o_not_sleep,
    output logic o_host_blocked,
    output logic o_ctrl_blocked,
    output logic o_guard_blocked
);
    typedef struct packed {
        suvmc_state_type st;
        logic [15:0] pu_cnt;
        logic [15:0] react_cnt;
        logic io_blk;
        suvmc_chan_type bat;
        suvmc_chan_type core;
        suvmc_chan_type io;
        logic [11:0] status_info_register;
        logic [1:0] host_mode;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [2:0] mode;
        logic tx_en;
        logic rx_en;
        logic rx_data;
        logic rx_act;
        logic err_n;
        logic not_sleep;
        logic host_blk;
        logic cc_blk;
        logic guard_blk;
    } suvmc_state_all_type;
    localparam suvmc_chan_type CHAN_RST = '0;
    localparam suvmc_state_all_type STATE_RST = '{
        st: ST_OFF,
        pu_cnt: 16'h0000,
        react_cnt: 16'h0000,
        io_blk: 1'b0,
        bat: CHAN_RST,
        core: CHAN_RST,
        io: CHAN_RST,
        status_info_register: `SUVMC_SIR_RST,
        host_mode: `SUVMC_HOST_STANDBY,
        prdata: 32'h0000_0000,
        pready: 1'b0,
        pslverr: 1'b0,
        mode: `SUVMC_MODE_OFF,
        tx_en: 1'b0,
        rx_en: 1'b0,
        rx_data: 1'b0,
        rx_act: 1'b0,
        err_n: 1'b0,
        not_sleep: 1'b0,
        host_blk: 1'b1,
        cc_blk: 1'b1,
        guard_blk: 1'b1
    };
    suvmc_state_all_type s_r;
    suvmc_state_all_type s_nxt;
    // One supply channel: blanking filter, detect timer, flag, recovery timer
    function automatic suvmc_chan_type chan_step(
        input suvmc_chan_type c,
        input logic uv,
        input logic start,
        input logic [15:0] blk_len,
        input logic [15:0] det_len,
        input logic [15:0] rec_len
    );
        suvmc_chan_type n;
        n = c;
        n.evt = 1'b0;
        if (!uv)
        begin
            n.blk = 16'h0000;
        end
        else if (c.blk != blk_len)
        begin
            // Dip must last the full blanking count before it counts
            n.blk = c.blk + 16'h0001;
            n.evt = (c.blk == blk_len - 16'h0001);
        end
        if ((n.evt || start) && !c.det_run && !c.flag)
        begin
            n.det_run = 1'b1;
            n.det = 16'h0000;
        end
        else if (c.det_run)
        begin
            if (!uv)
            begin
                n.det_run = 1'b0;
            end
            else if (c.det == det_len - 16'h0001)
            begin
                n.det_run = 1'b0;
                n.flag = 1'b1;
                n.rec = 16'h0000;
            end
            else
            begin
                n.det = c.det + 16'h0001;
            end
        end
        if (c.flag)
        begin
            if (uv)
            begin
                // Relapse restarts recovery, flag stays
                n.rec = 16'h0000;
            end
            else if (c.rec == rec_len - 16'h0001)
            begin
                n.flag = 1'b0;
                n.rec = 16'h0000;
            end
            else
            begin
                n.rec = c.rec + 16'h0001;
            end
        end
        return n;
    endfunction : chan_step
    logic supplies_ok;
    logic enter_interim;
    logic access;
    logic core_q;
    logic io_q;
    logic any_flag;
    logic lp_sleep;
    logic dig_low;
    always_comb
    begin
        s_nxt = s_r;
        supplies_ok = !i_sup.bat_uv && !i_sup.core_uv;
        enter_interim = (s_r.st == ST_POWERUP) && !supplies_ok &&
                        (s_r.pu_cnt == P_PWRUP - 16'h0001);
        access = i_psel && i_penable && !s_r.pready;
        // Interim entry starts the timers of the missing supplies
        s_nxt.bat = chan_step(s_r.bat, i_sup.bat_uv, enter_interim && i_sup.bat_uv,
                              P_BAT_BLK, P_BAT_DET, P_BAT_REC);
        s_nxt.core = chan_step(s_r.core, i_sup.core_uv, enter_interim && i_sup.core_uv,
                               P_CORE_BLK, P_CORE_DET, P_CORE_REC);
        s_nxt.io = chan_step(s_r.io, i_sup.io_uv, 1'b0, P_IO_BLK, P_IO_DET, P_IO_REC);
        core_q = i_sup.core_uv && (s_r.core.blk == P_CORE_BLK);
        io_q = i_sup.io_uv && (s_r.io.blk == P_IO_BLK);
        // Clear first so that a same-cycle event wins
        if (access && i_pwrite && (i_paddr == `SUVMC_OFS_CLEAR) && i_pwdata[0] &&
            !s_r.io_blk)
        begin
            s_nxt.status_info_register = `SUVMC_SIR_RST;
        end
        if (s_nxt.bat.evt)
        begin
            s_nxt.status_info_register[`SUVMC_BIT_BATUV] = 1'b1;
            s_nxt.status_info_register[`SUVMC_BIT_ERR] = 1'b1;
        end
        if (s_nxt.core.evt)
        begin
            s_nxt.status_info_register[`SUVMC_BIT_COREUV] = 1'b1;
            s_nxt.status_info_register[`SUVMC_BIT_ERR] = 1'b1;
        end
        if (core_q || s_nxt.core.evt)
        begin
            s_nxt.status_info_register[`SUVMC_BIT_BUSERR] = 1'b1;
        end
        if (s_nxt.io.evt)
        begin
            // Latched while software can still read the status register
            s_nxt.status_info_register[`SUVMC_BIT_IOUV] = 1'b1;
            s_nxt.status_info_register[`SUVMC_BIT_ERR] = 1'b1;
        end
        // Port blocking after the reaction time
        if (!io_q)
        begin
            s_nxt.react_cnt = 16'h0000;
            s_nxt.io_blk = 1'b0;
        end
        else if (s_r.react_cnt == P_IO_REACT - 16'h0001)
        begin
            s_nxt.io_blk = 1'b1;
        end
        else
        begin
            s_nxt.react_cnt = s_r.react_cnt + 16'h0001;
        end
        case (s_r.st)
            ST_OFF:
            begin
                // Leaving off needs only one supply above reset
                s_nxt.st = ST_POWERUP;
                s_nxt.pu_cnt = 16'h0000;
            end
            ST_POWERUP:
            begin
                if (supplies_ok)
                begin
                    s_nxt.st = ST_RUN;
                    s_nxt.host_mode = `SUVMC_HOST_STANDBY;
                end
                else if (enter_interim)
                begin
                    s_nxt.st = ST_INTERIM;
                end
                else
                begin
                    s_nxt.pu_cnt = s_r.pu_cnt + 16'h0001;
                end
            end
            ST_INTERIM:
            begin
                if (supplies_ok || s_nxt.bat.flag || s_nxt.core.flag)
                begin
                    s_nxt.st = ST_RUN;
                    s_nxt.host_mode = `SUVMC_HOST_STANDBY;
                end
            end
            ST_RUN:
            begin
                s_nxt.st = ST_RUN;
            end
            default:
            begin
                s_nxt.st = ST_OFF;
            end
        endcase
        any_flag = s_nxt.bat.flag || s_nxt.core.flag || s_nxt.io.flag;
        lp_sleep = s_nxt.bat.flag || s_nxt.io.flag;
        // Detect timers running alone never block the host
        s_nxt.host_blk = (s_nxt.st != ST_RUN) || any_flag || s_nxt.io_blk;
        s_nxt.cc_blk = lp_sleep || s_nxt.io_blk || (s_nxt.st == ST_OFF);
        s_nxt.guard_blk = s_nxt.io_blk || (s_nxt.st == ST_OFF);
        // APB slave: one wait state, then answer
        s_nxt.pready = access;
        s_nxt.pslverr = 1'b0;
        s_nxt.prdata = 32'h0000_0000;
        if (access)
        begin
            case (i_paddr)
                `SUVMC_OFS_STATUS:
                begin
                    if (s_r.io_blk)
                    begin
                        s_nxt.pslverr = !i_pwrite;
                    end
                    else if (!i_pwrite)
                    begin
                        s_nxt.prdata = {20'h00000, s_r.status_info_register};
                    end
                end
                `SUVMC_OFS_CTRL:
                begin
                    if (i_pwrite && s_r.host_blk)
                    begin
                        // Refused in interim, under any flag or port block
                        s_nxt.pslverr = 1'b1;
                    end
                    else if (i_pwrite)
                    begin
                        s_nxt.host_mode = i_pwdata[1:0];
                    end
                    else
                    begin
                        s_nxt.prdata = {30'h0000_0000, s_r.host_mode};
                    end
                end
                `SUVMC_OFS_MODE:
                begin
                    if (!i_pwrite)
                    begin
                        s_nxt.prdata = {24'h000000, s_r.host_blk, s_r.io.flag,
                                        s_r.core.flag, s_r.bat.flag, 1'b0, s_r.mode};
                    end
                end
                `SUVMC_OFS_CLEAR:
                begin
                    s_nxt.pslverr = s_r.io_blk && i_pwrite;
                end
                default:
                begin
                    s_nxt.pslverr = 1'b1;
                end
            endcase
        end
        // Flags override the host-selected mode
        if (s_nxt.st == ST_OFF)
        begin
            s_nxt.mode = `SUVMC_MODE_OFF;
        end
        else if (s_nxt.st != ST_RUN)
        begin
            s_nxt.mode = `SUVMC_MODE_INTERIM;
        end
        else if (lp_sleep)
        begin
            s_nxt.mode = `SUVMC_MODE_SLEEP;
        end
        else if (s_nxt.core.flag)
        begin
            s_nxt.mode = `SUVMC_MODE_STANDBY;
        end
        else
        begin
            case (s_nxt.host_mode)
                `SUVMC_HOST_NORMAL:
                begin
                    s_nxt.mode = `SUVMC_MODE_NORMAL;
                end
                `SUVMC_HOST_RXONLY:
                begin
                    s_nxt.mode = `SUVMC_MODE_RXONLY;
                end
                `SUVMC_HOST_SLEEP:
                begin
                    s_nxt.mode = `SUVMC_MODE_SLEEP;
                end
                default:
                begin
                    s_nxt.mode = `SUVMC_MODE_STANDBY;
                end
            endcase
        end
        s_nxt.tx_en = (s_nxt.mode == `SUVMC_MODE_NORMAL) && !i_sup.core_uv;
        s_nxt.rx_en = (s_nxt.mode == `SUVMC_MODE_NORMAL) ||
                      (s_nxt.mode == `SUVMC_MODE_RXONLY);
        s_nxt.not_sleep = (s_nxt.mode != `SUVMC_MODE_SLEEP) &&
                          (s_nxt.mode != `SUVMC_MODE_OFF);
        // Idle receive lines sit high; pins are only trusted with a good reference
        dig_low = s_nxt.io_blk || (s_nxt.st == ST_OFF);
        s_nxt.rx_data = !dig_low && (!s_nxt.rx_en || i_bus_rx_data);
        s_nxt.rx_act = !dig_low && s_nxt.rx_en && i_bus_rx_act;
        s_nxt.err_n = !dig_low && !s_nxt.status_info_register[`SUVMC_BIT_ERR];
        // Both supplies gone: volatile state is lost
        if (i_sup.bat_pd && i_sup.core_pd)
        begin
            s_nxt = STATE_RST;
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            s_r <= STATE_RST;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end
    assign o_prdata = s_r.prdata;
    assign o_pready = s_r.pready;
    assign o_pslverr = s_r.pslverr;
    assign o_mode = s_r.mode;
    assign o_tx_en = s_r.tx_en;
    assign o_rx_en = s_r.rx_en;
    assign o_rx_data = s_r.rx_data;
    assign o_receive_activity_output = s_r.rx_act;
    assign o_error_indication_output_n = s_r.err_n;
    assign o_not_sleep = s_r.not_sleep;
    assign o_host_blocked = s_r.host_blk;
    assign o_ctrl_blocked = s_r.cc_blk;
    assign o_guard_blocked = s_r.guard_blk;
endmodule : suvmc_top
`default_nettype wire

// file: tb/suvmc_asserts.sv
// Port-level checks of the supply supervision block
`default_nettype none
module suvmc_asserts
    import suvmc_pkg::*;
#(
    parameter logic [15:0] P_IO_BLK = 16'h2,
    parameter logic [15:0] P_IO_REACT = 16'h2
)
(
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire suvmc_supply_type i_sup,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [2:0] o_mode,
    input wire logic o_tx_en,
    input wire logic o_rx_data,
    input wire logic o_receive_activity_output,
    input wire logic o_error_indication_output_n,
    input wire logic o_not_sleep,
    input wire logic o_host_blocked,
    input wire logic o_ctrl_blocked,
    input wire logic o_guard_blocked
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_nrst);
    logic pd_both;
    logic any_dn;
    logic [15:0] io_cnt_r;
    assign pd_both = i_sup.bat_pd & i_sup.core_pd;
    assign any_dn = i_sup.bat_uv | i_sup.core_uv | i_sup.io_uv | pd_both;
    // Consecutive I/O dip length; power-down restarts qualification
    always_ff @(posedge i_ref_clk or negedge i_nrst)
        if (!i_nrst)
            io_cnt_r <= 16'h0;
        else if (!i_sup.io_uv || pd_both)
            io_cnt_r <= 16'h0;
        else if (io_cnt_r != 16'hffff)
            io_cnt_r <= io_cnt_r + 16'h1;

    err_cause_a: assert property ($fell(o_error_indication_output_n) |->
        ($past(any_dn) || $past(any_dn, 2))) else $error("error output fell without a fault");
    tx_core_a: assert property (i_sup.core_uv |=> !o_tx_en)
        else $error("transmitter enabled during core dip");
    io_quiet_a: assert property (io_cnt_r > P_IO_BLK + P_IO_REACT + 16'h1 |->
        o_guard_blocked && o_ctrl_blocked && o_host_blocked && !o_rx_data &&
        !o_receive_activity_output && !o_error_indication_output_n)
        else $error("ports not quiet during I/O dip");
    off_state_a: assert property (pd_both |=> o_mode == 3'h0 && !o_not_sleep &&
        !o_tx_en && !o_rx_data && !o_receive_activity_output)
        else $error("power-down did not reach off state");
    pwrup_done_a: assert property (o_mode == 3'h5 && !any_dn |=> o_mode == 3'h1)
        else $error("good supplies did not give standby");
    interim_host_a: assert property (o_mode == 3'h5 |-> o_host_blocked)
        else $error("host open during power-up");
    ctrl_refuse_a: assert property (i_psel && i_penable && i_pwrite && i_paddr == 8'h04 &&
        o_host_blocked && !o_pready |=> o_pready && o_pslverr)
        else $error("blocked control write not refused");
    flag_block_a: assert property (o_ctrl_blocked |-> o_host_blocked)
        else $error("controller blocked while host open");
endmodule : suvmc_asserts

bind suvmc_top suvmc_asserts #(.P_IO_BLK(P_IO_BLK), .P_IO_REACT(P_IO_REACT)) u_chk (
    .i_ref_clk, .i_nrst, .i_sup, .i_psel, .i_penable, .i_pwrite, .i_paddr, .o_pready,
    .o_pslverr, .o_mode, .o_tx_en, .o_rx_data, .o_receive_activity_output,
    .o_error_indication_output_n, .o_not_sleep, .o_host_blocked, .o_ctrl_blocked,
    .o_guard_blocked);
`default_nettype wire

// file: tb/suvmc_bus_model.sv
// Far-side bus receiver model: idle-high data with bursts of activity
`default_nettype none
module suvmc_bus_model
(
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    output logic o_rx_data,
    output logic o_rx_act
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [4:0] cnt_r;
    always_ff @(posedge i_ref_clk or negedge i_nrst)
        if (!i_nrst)
            cnt_r <= 5'h00;
        else
            cnt_r <= cnt_r + 5'h01;
    // Data toggles only inside activity bursts
    assign o_rx_act = cnt_r[4];
    assign o_rx_data = !cnt_r[4] | (cnt_r[0] ^ cnt_r[2]);
endmodule : suvmc_bus_model
`default_nettype wire

// file: tb/test_suvmc_top.sv
// Self-checking bench of the supply supervision block
`default_nettype none
module test_suvmc_top
    import suvmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, e;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, q, prdata;
    suvmc_supply_type sup = '0;
    logic rxd, rxa, pready, pslverr, tx_en, rx_en, rx_data, ract, err_n, nsl, hb, cb, gb;
    logic [2:0] mode;
    int error_cnt = 0, n_tests = 0, cyc = 0;
    // Short timings keep every scenario within a few hundred cycles
    localparam logic [15:0] T_BLK = 16'h2;
    localparam logic [15:0] T_DET = 16'h10;
    localparam logic [15:0] T_REC = 16'h8;

    always #25 clk = ~clk;
    suvmc_bus_model u_far (.i_ref_clk(clk), .i_nrst(nrst), .o_rx_data(rxd), .o_rx_act(rxa));
    suvmc_top #(.P_BAT_BLK(T_BLK), .P_BAT_DET(T_DET), .P_BAT_REC(T_REC), .P_CORE_BLK(T_BLK),
        .P_CORE_DET(T_DET), .P_CORE_REC(T_REC), .P_IO_BLK(T_BLK), .P_IO_DET(T_DET),
        .P_IO_REC(T_REC), .P_IO_REACT(T_BLK), .P_PWRUP(T_REC)) DUT (
        .i_ref_clk(clk), .i_nrst(nrst), .i_sup(sup), .i_bus_rx_data(rxd), .i_bus_rx_act(rxa),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_mode(mode), .o_tx_en(tx_en), .o_rx_en(rx_en), .o_rx_data(rx_data),
        .o_receive_activity_output(ract), .o_error_indication_output_n(err_n),
        .o_not_sleep(nsl), .o_host_blocked(hb), .o_ctrl_blocked(cb), .o_guard_blocked(gb));

    task automatic summarize;
        if (error_cnt == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : summarize

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %0t ns: saw %h expected %h", $time, got, exp);
        end
    endtask : chk

    // One transfer; ends one edge after release so the next setup never collides
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20)
        begin
            chk(33'(pready), 33'h1);
            summarize();
        end
        @(posedge clk);
    endtask : apb

    task automatic wmode(input logic [2:0] m, input int lim);
        int n;
        n = 0;
        while (mode !== m && n < lim)
        begin
            @(posedge clk);
            n++;
        end
        chk(33'(mode), 33'(m));
    endtask : wmode

    task automatic t_host;
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b1, 8'h04, 32'(i));
            chk(33'({mode, tx_en, nsl, rx_en}),
                33'({3'(i + 1), i == 1, i != 3, i == 1 || i == 2}));
        end
        apb(1'b0, 8'h10, 32'h0);
        chk({e, q}, 33'h100000000);
        apb(1'b1, 8'h04, 32'h1);
    endtask : t_host

    task automatic t_bat;
        // One-cycle dip on all three supplies, shorter than every blanking time
        sup <= 5'h1c;
        @(posedge clk);
        sup <= 5'h00;
        repeat (4) @(posedge clk);
        apb(1'b0, 8'h00, 32'h0);
        chk({e, q}, 33'h0);
        sup.bat_uv <= 1'b1;
        repeat (3) @(posedge clk);
        apb(1'b0, 8'h00, 32'h0);
        chk({e, q}, 33'h900);
        chk(33'(mode), 33'h2);
        wmode(3'h4, 24);
        chk(33'({hb, cb}), 33'h3);
        sup.bat_uv <= 1'b0;
        repeat (4) @(posedge clk);
        sup.bat_uv <= 1'b1;
        @(posedge clk);
        sup.bat_uv <= 1'b0;
        repeat (6) @(posedge clk);
        chk(33'(mode), 33'h4);
        wmode(3'h2, 8);
        apb(1'b0, 8'h00, 32'h0);
        chk({e, q}, 33'h900);
        apb(1'b1, 8'h0c, 32'h1);
        apb(1'b0, 8'h00, 32'h0);
        chk({e, q}, 33'h0);
    endtask : t_bat

    task automatic t_core;
        sup.core_uv <= 1'b1;
        repeat (3) @(posedge clk);
        chk(33'(tx_en), 33'h0);
        apb(1'b0, 8'h00, 32'h0);
        chk({e, q}, 33'ha10);
        sup.core_uv <= 1'b0;
        repeat (20) @(posedge clk);
        chk(33'({mode, hb}), 33'h4);
        apb(1'b1, 8'h0c, 32'h1);
        sup.core_uv <= 1'b1;
        wmode(3'h1, 24);
        chk(33'({hb, cb, tx_en}), 33'h4);
        apb(1'b1, 8'h04, 32'h2);
        chk(33'(e), 33'h1);
        sup.core_uv <= 1'b0;
        wmode(3'h2, 16);
        apb(1'b1, 8'h0c, 32'h1);
    endtask : t_core

    task automatic t_io;
        sup.io_uv <= 1'b1;
        repeat (8) @(posedge clk);
        chk(33'({gb, rx_data, ract, err_n}), 33'h8);
        apb(1'b0, 8'h00, 32'h0);
        chk({e, q}, 33'h100000000);
        wmode(3'h4, 24);
        sup.io_uv <= 1'b0;
        wmode(3'h2, 16);
        apb(1'b0, 8'h00, 32'h0);
        chk({e, q}, 33'hc00);
        apb(1'b1, 8'h0c, 32'h1);
    endtask : t_io

    task automatic t_pd;
        sup.bat_uv <= 1'b1;
        repeat (3) @(posedge clk);
        sup.bat_uv <= 1'b0;
        sup.bat_pd <= 1'b1;
        repeat (3) @(posedge clk);
        chk(33'(mode), 33'h2);
        sup.core_pd <= 1'b1;
        repeat (2) @(posedge clk);
        chk(33'({mode, nsl, err_n, tx_en, rx_data}), 33'h0);
        sup.bat_pd <= 1'b0;
        wmode(3'h1, 4);
        apb(1'b0, 8'h00, 32'h0);
        chk({e, q}, 33'h0);
        sup.core_pd <= 1'b0;
    endtask : t_pd

    task automatic t_interim;
        for (int k = 0; k < 2; k++)
        begin
            nrst <= 1'b0;
            sup.bat_uv <= 1'b1;
            repeat (2) @(posedge clk);
            nrst <= 1'b1;
            repeat (12) @(posedge clk);
            chk(33'({mode, hb}), 33'hb);
            if (k == 0)
            begin
                apb(1'b1, 8'h04, 32'h1);
                chk(33'(e), 33'h1);
            end
            else
                wmode(3'h4, 24);
            sup.bat_uv <= 1'b0;
            wmode(3'h1, 16);
        end
    endtask : t_interim

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            summarize();
        end
    end

    initial
    begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        wmode(3'h1, 4);
        t_host();
        t_bat();
        t_core();
        t_io();
        t_pd();
        apb(1'b1, 8'h04, 32'h1);
        t_interim();
        summarize();
    end
endmodule : test_suvmc_top
`default_nettype wire
